// ---- src/key_update_gate.sv ----
// Purpose: Gates status, pending and interrupt updates for one key column.
// Assumes: Scan results arrive as a 4-bit row vector per column.
// Notes:   Key mask touches only status; column mask touches all three.
`timescale 1ns/1ns
module key_update_gate
  import keypad_cfg_pkg::*;
(
  input  wire logic [3:0] row_hits,
  input  wire logic [3:0] key_mask,
  input  wire logic       col_mask,
  output logic      [3:0] status_upd,
  output logic      [3:0] pending_upd,
  output logic            irq_upd
);
  // Column mask wins over everything; key mask spares the pending path
  assign status_upd  = col_mask ? 4'h0 : (row_hits & ~key_mask);
  assign pending_upd = col_mask ? 4'h0 : row_hits;
  assign irq_upd     = ~col_mask & (|row_hits);
endmodule

// ---- src/keypad_cfg_pkg.sv ----
// Purpose: Shared constants for the keypad scan timing and GPIO pin mux.
// Assumes: 125 MHz ref_clk, 16-bit registers reached through a register port.
// Notes:   Register indices are local choices; field positions follow layout.
package keypad_cfg_pkg;

  // ---------------------------------------------------------------------------
  // Register indices on the register port
  // ---------------------------------------------------------------------------
  localparam logic [2:0] REG_KEYPAD_CTRL    = 3'h0;
  localparam logic [2:0] REG_KEY_MASK       = 3'h1;
  localparam logic [2:0] REG_COLUMN_MASK    = 3'h2;
  localparam logic [2:0] REG_PIN_FUNC_DIR   = 3'h3;
  localparam logic [2:0] REG_PULLUP_DISABLE = 3'h4;
  localparam logic [2:0] REG_GPIO_STATE     = 3'h5;

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int DEBOUNCE_MSB   = 13;
  localparam int DEBOUNCE_LSB   = 11;
  localparam int HOLD_MSB       = 10;
  localparam int HOLD_LSB       = 8;
  localparam int COL_MASK_LSB   = 12;
  localparam int GPIO_SEL_LSB   = 8;
  localparam int PULLUP_LSB     = 8;
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  localparam logic [15:0] KEY_MASK_RESET = 16'h0000;
  localparam logic [15:0] COL_MASK_RESET = 16'h0000;
  localparam logic [15:0] FUNC_RESET     = 16'h0000;
  localparam logic [15:0] PULLUP_RESET   = 16'h0000;
  localparam logic [15:0] COL_MASK_BITS  = 16'hF000;
  localparam logic [15:0] UPPER_BYTE     = 16'hFF00;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ         = 125;
  localparam int TICK_US         = 1;
  localparam int TICK_CYCLES     = TICK_US * CLK_MHZ;
  localparam int HOLD_SHORT_US   = 100;
  localparam int HOLD_SHORT_TICKS = HOLD_SHORT_US / TICK_US;
  localparam int DEBOUNCE_MS [8] = '{2, 10, 20, 50, 60, 80, 100, 120};
  localparam int US_PER_MS       = 1000;

  typedef enum logic [1:0] {ST_IDLE, ST_DEBOUNCE, ST_HOLD} scan_state_t;

endpackage

// ---- src/keypad_scan_config_gpio_mux.sv ----
// Purpose: Keypad scan configuration registers, debounce/hold timing and
//          pin reuse of the eight row/column lines as GPIO.
// Assumes: Synchronous active-high reset; register port writes are one-cycle.
// Notes:   The scan state machine itself lives outside; it feeds key_hits.
`timescale 1ns/1ns
module keypad_scan_config_gpio_mux
  import keypad_cfg_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        reg_wr,
  input  wire logic [2:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic        scan_start,
  input  wire logic        key_held,
  input  wire logic [15:0] key_hits,
  output logic             debounce_done,
  output logic             hold_done,
  output logic      [15:0] status_update,
  output logic      [15:0] pending_update,
  output logic             key_irq,
  input  wire logic [7:0]  pin_in,
  output logic      [7:0]  pin_out,
  output logic      [7:0]  pin_oe,
  output logic      [7:0]  pin_pullup_en,
  output logic      [7:0]  gpio_mode,
  input  wire logic [7:0]  keypad_out,
  input  wire logic [7:0]  keypad_oe,
  output logic      [7:0]  keypad_in
);

  // ---------------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------------
  logic [15:0] keypad_ctrl;
  logic [15:0] per_key_update_mask;
  logic [15:0] column_event_mask;
  logic [15:0] pin_function_direction_control;
  logic [15:0] pin_pullup_disable;
  logic [7:0]  gpio_in_q;

  // Reserved bits are never stored so they always read back as zero
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      keypad_ctrl                    <= CTRL_RESET;
      per_key_update_mask            <= KEY_MASK_RESET;
      column_event_mask              <= COL_MASK_RESET;
      pin_function_direction_control <= FUNC_RESET;
      pin_pullup_disable             <= PULLUP_RESET;
    end else if (reg_wr) begin
      if (reg_addr == REG_KEYPAD_CTRL) begin
        keypad_ctrl <= reg_wdata & 16'h3F00;
      end else if (reg_addr == REG_KEY_MASK) begin
        per_key_update_mask <= reg_wdata;
      end else if (reg_addr == REG_COLUMN_MASK) begin
        column_event_mask <= reg_wdata & COL_MASK_BITS;
      end else if (reg_addr == REG_PIN_FUNC_DIR) begin
        pin_function_direction_control <= reg_wdata;
      end else if (reg_addr == REG_PULLUP_DISABLE) begin
        pin_pullup_disable <= reg_wdata & UPPER_BYTE;
      end
    end
  end

  // Read mux is registered so reg_rdata comes straight from a flip-flop
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_addr == REG_KEYPAD_CTRL) begin
      reg_rdata <= keypad_ctrl;
    end else if (reg_addr == REG_KEY_MASK) begin
      reg_rdata <= per_key_update_mask;
    end else if (reg_addr == REG_COLUMN_MASK) begin
      reg_rdata <= column_event_mask;
    end else if (reg_addr == REG_PIN_FUNC_DIR) begin
      reg_rdata <= pin_function_direction_control;
    end else if (reg_addr == REG_PULLUP_DISABLE) begin
      reg_rdata <= pin_pullup_disable;
    end else if (reg_addr == REG_GPIO_STATE) begin
      reg_rdata <= {8'h00, gpio_in_q};
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ---------------------------------------------------------------------------
  // Timebase and delay decode
  // ---------------------------------------------------------------------------
  logic [2:0]  debounce_sel;
  logic [2:0]  hold_sel;
  logic [6:0]  tick_div;
  logic        tick;
  logic [19:0] debounce_ticks;
  logic [19:0] hold_ticks;

  assign debounce_sel = keypad_ctrl[DEBOUNCE_MSB:DEBOUNCE_LSB];
  assign hold_sel     = keypad_ctrl[HOLD_MSB:HOLD_LSB];

  // Debounce table in microsecond ticks
  always_comb begin
    debounce_ticks = 20'(DEBOUNCE_MS[debounce_sel] * US_PER_MS);
    if (hold_sel == 3'h0) begin
      hold_ticks = 20'(HOLD_SHORT_TICKS);
    end else begin
      hold_ticks = debounce_ticks;
    end
  end

  // One-microsecond tick keeps the delay counter narrow
  always_ff @(posedge ref_clk) begin
    if (srst || scan_start) begin
      tick_div <= 7'h00;
      tick     <= 1'b0;
    end else if (tick_div == 7'(TICK_CYCLES - 1)) begin
      tick_div <= 7'h00;
      tick     <= 1'b1;
    end else begin
      tick_div <= tick_div + 7'h01;
      tick     <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Debounce and hold sequencer
  // ---------------------------------------------------------------------------
  scan_state_t state;
  logic [19:0] delay_cnt;
  logic [2:0]  periods_left;

  // Counter reloads at every interval start; hold repeats whole periods
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state         <= ST_IDLE;
      delay_cnt     <= 20'h00000;
      periods_left  <= 3'h0;
      debounce_done <= 1'b0;
      hold_done     <= 1'b0;
    end else begin
      debounce_done <= 1'b0;
      hold_done     <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (scan_start) begin
            state     <= ST_DEBOUNCE;
            delay_cnt <= debounce_ticks;
          end
        end
        ST_DEBOUNCE: begin
          if (tick && delay_cnt <= 20'h00001) begin
            debounce_done <= 1'b1;
            if (key_held) begin
              state        <= ST_HOLD;
              delay_cnt    <= hold_ticks;
              periods_left <= (hold_sel == 3'h0) ? 3'h0 : hold_sel - 3'h1;
            end else begin
              state <= ST_IDLE;
            end
          end else if (tick) begin
            delay_cnt <= delay_cnt - 20'h00001;
          end
        end
        ST_HOLD: begin
          if (!key_held) begin
            state <= ST_IDLE;
          end else if (tick && delay_cnt <= 20'h00001) begin
            if (periods_left != 3'h0) begin
              periods_left <= periods_left - 3'h1;
              delay_cnt    <= debounce_ticks;
            end else begin
              hold_done <= 1'b1;
              state     <= ST_DEBOUNCE;
              delay_cnt <= debounce_ticks;
            end
          end else if (tick) begin
            delay_cnt <= delay_cnt - 20'h00001;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Per-column update gating
  // ---------------------------------------------------------------------------
  logic [15:0] next_status;
  logic [15:0] next_pending;
  logic [3:0]  col_irq;

  // Bit index is column*4+row, so each column is a 4-bit slice
  genvar c;
  generate
    for (c = 0; c < 4; c++) begin : g_col
      key_update_gate key_update_gate_inst (
        .row_hits    (key_hits[c*4 +: 4]),
        .key_mask    (per_key_update_mask[c*4 +: 4]),
        .col_mask    (column_event_mask[COL_MASK_LSB + c]),
        .status_upd  (next_status[c*4 +: 4]),
        .pending_upd (next_pending[c*4 +: 4]),
        .irq_upd     (col_irq[c])
      );
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      status_update  <= 16'h0000;
      pending_update <= 16'h0000;
      key_irq        <= 1'b0;
    end else begin
      status_update  <= next_status;
      pending_update <= next_pending;
      key_irq        <= |col_irq;
    end
  end

  // ---------------------------------------------------------------------------
  // Pin mux: bits 7..4 are columns 4..1, bits 3..0 rows 4..1
  // ---------------------------------------------------------------------------
  logic [7:0] gpio_sel;
  logic [7:0] gpio_dir_out;
  logic [7:0] gpio_drive;
  logic [7:0] pullup_off;

  assign gpio_sel     = pin_function_direction_control[15:GPIO_SEL_LSB];
  assign gpio_dir_out = pin_function_direction_control[7:0];
  assign pullup_off   = pin_pullup_disable[15:PULLUP_LSB];
  // GPIO output value comes from the state register's low byte of writes
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      gpio_drive <= 8'h00;
    end else if (reg_wr && reg_addr == REG_GPIO_STATE) begin
      gpio_drive <= reg_wdata[7:0];
    end
  end

  // Open-collector pins only pull low; high is left to the pull-up or load
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pin_out       <= 8'h00;
      pin_oe        <= 8'h00;
      pin_pullup_en <= 8'hFF;
      gpio_mode     <= 8'h00;
      keypad_in     <= 8'h00;
      gpio_in_q     <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (gpio_sel[i]) begin
          pin_out[i] <= gpio_drive[i];
          pin_oe[i]  <= gpio_dir_out[i] &
                        (~pullup_off[i] | ~gpio_drive[i]);
        end else begin
          pin_out[i] <= keypad_out[i];
          pin_oe[i]  <= keypad_oe[i];
        end
      end
      pin_pullup_en <= ~pullup_off;
      gpio_mode     <= gpio_sel;
      keypad_in     <= pin_in & ~gpio_sel;
      gpio_in_q     <= pin_in & gpio_sel;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  property p_colmask_blocks;
    @(posedge ref_clk) disable iff (srst)
      column_event_mask[COL_MASK_LSB] |=> (status_update[3:0] == 4'h0 &&
        pending_update[3:0] == 4'h0);
  endproperty
  a_colmask_blocks: assert property (p_colmask_blocks)
    else $error("column mask did not block column 1");

  property p_keymask_pending;
    @(posedge ref_clk) disable iff (srst)
      column_event_mask == 16'h0000 |=> pending_update == $past(key_hits);
  endproperty
  a_keymask_pending: assert property (p_keymask_pending)
    else $error("pending update altered by key mask");

  property p_keymask_status;
    @(posedge ref_clk) disable iff (srst)
      (per_key_update_mask[0] && key_hits[0]) |=> !status_update[0];
  endproperty
  a_keymask_status: assert property (p_keymask_status)
    else $error("key mask did not block status bit 0");

  property p_gpio_dir;
    @(posedge ref_clk) disable iff (srst)
      (gpio_sel[0] && !gpio_dir_out[0]) |=> !pin_oe[0];
  endproperty
  a_gpio_dir: assert property (p_gpio_dir)
    else $error("input GPIO is driving");

  property p_keypad_func;
    @(posedge ref_clk) disable iff (srst)
      !gpio_sel[7] |=> pin_oe[7] == $past(keypad_oe[7]);
  endproperty
  a_keypad_func: assert property (p_keypad_func)
    else $error("keypad pin not following keypad logic");

  property p_open_collector;
    @(posedge ref_clk) disable iff (srst)
      (gpio_sel[5] && pullup_off[5] && gpio_drive[5]) |=> !pin_oe[5];
  endproperty
  a_open_collector: assert property (p_open_collector)
    else $error("open collector pin drove high");

  property p_hold_short;
    @(posedge ref_clk) disable iff (srst)
      (state == ST_HOLD && debounce_done && hold_sel == 3'h0)
        |-> delay_cnt == 20'(HOLD_SHORT_TICKS);
  endproperty
  a_hold_short: assert property (p_hold_short)
    else $error("short hold not loaded with 100 us");

  property p_debounce_load;
    @(posedge ref_clk) disable iff (srst)
      (state == ST_IDLE && scan_start && debounce_sel == 3'h0)
        |=> delay_cnt == 20'h007D0;
  endproperty
  a_debounce_load: assert property (p_debounce_load)
    else $error("2 ms debounce not loaded");

endmodule

// ---- tb/keypad_scan_config_gpio_mux_test.sv ----
// Purpose: Register, key gating, pin mux and timing checks of the block.
// Assumes: Inputs change on the falling edge; reads answer one edge later.
// Notes:   A full 2 ms debounce exceeds the run budget; only early firing
//          is checked.
`timescale 1ns/1ns
module keypad_scan_config_gpio_mux_test
  import keypad_cfg_pkg::*;
;
  logic        ref_clk, srst, reg_wr, scan_start, key_held, debounce_done;
  logic        hold_done, key_irq;
  logic [2:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, key_hits, status_update, pending_update;
  logic [7:0]  pin_in, pin_out, pin_oe, pin_pullup_en, gpio_mode;
  logic [7:0]  keypad_out, keypad_oe, keypad_in, ext_val, ext_oe;
  logic [15:0] seen;
  logic [15:0] km [3] = '{16'h0081, 16'hFFFF, 16'h0000};
  logic [15:0] cm [3] = '{16'hAFFF, 16'h0000, 16'hF000};
  logic [15:0] hit [3] = '{16'hFFFF, 16'h0001, 16'h8421};
  int          failures = 0;
  int          check_count = 0;

  keypad_scan_config_gpio_mux keypad_scan_config_gpio_mux_inst (
    .ref_clk(ref_clk), .srst(srst), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .scan_start(scan_start),
    .key_held(key_held), .key_hits(key_hits),
    .debounce_done(debounce_done), .hold_done(hold_done),
    .status_update(status_update), .pending_update(pending_update),
    .key_irq(key_irq), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pullup_en), .gpio_mode(gpio_mode),
    .keypad_out(keypad_out), .keypad_oe(keypad_oe), .keypad_in(keypad_in));

  pin_side_model pin_side_model_inst (
    .ref_clk(ref_clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pullup_en), .ext_val(ext_val), .ext_oe(ext_oe),
    .pin_in(pin_in));

  // ---------------------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask

  // Write strobe held across exactly one rising edge
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [15:0] exp);
    @(negedge ref_clk);
    reg_addr = a;
    @(negedge ref_clk);
    check(reg_rdata, exp);
  endtask

  // Column mask bits 15:12 widened onto their four keys each
  function automatic logic [15:0] col_keys(input logic [15:0] c);
    for (int i = 0; i < 4; i++)
      col_keys[i*4 +: 4] = {4{c[12+i]}};
  endfunction

  task automatic results;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ---------------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------------
  initial begin
    srst = 1'b1; reg_wr = 1'b0; reg_addr = 3'h0; reg_wdata = 16'h0000;
    scan_start = 1'b0; key_held = 1'b0; key_hits = 16'h0000;
    keypad_out = 8'h0A; keypad_oe = 8'h0F; ext_val = 8'h3C; ext_oe = 8'hFF;
    repeat (2) @(negedge ref_clk);
    srst = 1'b0;
    // Reset values, then unmapped and reserved bits
    for (int a = 0; a < 8; a++)
      rd_chk(a[2:0], 16'h0000);
    wr(3'h6, 16'hFFFF);
    wr(3'h7, 16'hFFFF);
    wr(REG_KEYPAD_CTRL, 16'hFFFF);
    wr(REG_PULLUP_DISABLE, 16'hFFFF);
    wr(REG_KEY_MASK, 16'hFFFF);
    rd_chk(3'h6, 16'h0000);
    rd_chk(3'h7, 16'h0000);
    rd_chk(REG_KEYPAD_CTRL, 16'h3F00);
    rd_chk(REG_PULLUP_DISABLE, 16'hFF00);
    rd_chk(REG_KEY_MASK, 16'hFFFF);
    $display("test registers done");
    // Key and column masking, three mixes
    for (int i = 0; i < 3; i++) begin
      wr(REG_KEY_MASK, km[i]);
      wr(REG_COLUMN_MASK, cm[i]);
      rd_chk(REG_COLUMN_MASK, cm[i] & 16'hF000);
      key_hits = hit[i];
      repeat (2) @(negedge ref_clk);
      check(status_update, hit[i] & ~km[i] & ~col_keys(cm[i]));
      check(pending_update, hit[i] & ~col_keys(cm[i]));
      check({15'h0, key_irq}, {15'h0, |(hit[i] & ~col_keys(cm[i]))});
    end
    $display("test masking done");
    // Pins: mode A5, direction F0, GPIO values FF, pin 5 open collector
    wr(REG_PIN_FUNC_DIR, 16'hA5F0);
    wr(REG_GPIO_STATE, 16'h00FF);
    wr(REG_PULLUP_DISABLE, 16'h2000);
    repeat (2) @(negedge ref_clk);
    check({8'h00, gpio_mode}, 16'h00A5);
    check({8'h00, pin_oe}, 16'h008A);
    check({8'h00, pin_out & 8'h8A}, 16'h008A);
    check({8'h00, pin_pullup_en}, 16'h00DF);
    check({8'h00, keypad_in}, 16'h001A);
    rd_chk(REG_GPIO_STATE, 16'h00A4);
    $display("test pins done");
    // Debounce must not end well before 2 ms; a hit aborts nothing here
    wr(REG_KEYPAD_CTRL, 16'h0000);
    scan_start = 1'b1;
    @(negedge ref_clk);
    scan_start = 1'b0;
    seen = 16'h0000;
    repeat (60000) begin
      @(negedge ref_clk);
      seen = seen | {14'h0, debounce_done, hold_done};
    end
    check(seen, 16'h0000);
    $display("test timing done");
    // Second reset in mid-run restores defaults
    srst = 1'b1;
    repeat (2) @(negedge ref_clk);
    srst = 1'b0;
    @(negedge ref_clk);
    check({pin_pullup_en, gpio_mode}, 16'hFF00);
    rd_chk(REG_PIN_FUNC_DIR, 16'h0000);
    rd_chk(REG_COLUMN_MASK, 16'h0000);
    $display("test reset done");
    results();
  end
endmodule

// ---- tb/pin_side_model.sv ----
// Purpose: Outside world at the eight pins: external drivers, pull-ups.
// Assumes: The outside drives only where ext_oe is set.
// Notes:   A floating line without pull-up toggles so stale values fail.
`timescale 1ns/1ns
module pin_side_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pullup_en,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_oe,
  output logic      [7:0] pin_in
);
  logic [7:0] float_pat = 8'h55;

  // Floating pattern flips every cycle, never settling to one level
  always @(posedge ref_clk) begin
    float_pat <= ~float_pat;
  end

  // Wire level from every party's enable, device drive first
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (ext_oe[i])
        pin_in[i] = ext_val[i];
      else if (pin_pullup_en[i])
        pin_in[i] = 1'b1;
      else
        pin_in[i] = float_pat[i];
    end
  end
endmodule
